// >>> hw/purs_top.sv
// Power-up reset sequencer: phases, pin filters, warm reset, cause flags
`timescale 1ns/10ps
`default_nettype none

// Function
// - Start only with supplies good, reset released
// - Run oscillator, fuse, pump phases in order
// - Bank phase then release processor reset
// - Filter power-on reset pin glitches
// - Drive warm reset low, open drain only
// - External low on warm line resets device
// - Filter warm reset input glitches
// - Hold warm line 2256 cycles after power-on
// - Hold warm line 32 cycles other causes
// - Power-up sets exception bit 15
// - Oscillator fail sets global bit 0
// - PLL slip sets global bits 8, 9
// - Watchdog sets exception bit 13
// - Self-test bit 5, software 4, external 3
// - Memory checks, vector port, MPU off after reset
// - Low supply asserts power-on reset, low core supply tristates outputs
module purs_top
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              power_on_reset_n_pin,
  input  wire logic              core_power_good,
  input  wire logic              io_power_good,
  input  wire logic              warm_reset_n_line_i,
  output var  logic              warm_reset_n_line_o,
  output var  logic              warm_reset_n_line_oe,
  input  wire purs_pkg::purs_req_s req,
  input  wire purs_pkg::purs_feat_s feat_en,
  input  wire logic [15:0]       exc_clr,
  input  wire logic [15:0]       glb_clr,
  output var  logic [15:0]       exc_status,
  output var  logic [15:0]       glb_status,
  output var  logic              cpu_reset_n,
  output var  logic [31:0]       boot_addr,
  output var  logic              outputs_hiz,
  output var  purs_pkg::purs_feat_s feat
);
  import purs_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] por_s_r, warm_s_r, cpg_s_r, iopg_s_r;
  logic [1:0] por_s_nxt, warm_s_nxt, cpg_s_nxt, iopg_s_nxt;

  always_comb
  begin
    por_s_nxt  = {por_s_r[0], power_on_reset_n_pin};
    warm_s_nxt = {warm_s_r[0], warm_reset_n_line_i};
    cpg_s_nxt  = {cpg_s_r[0], core_power_good};
    iopg_s_nxt = {iopg_s_r[0], io_power_good};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      por_s_r  <= 2'h0;
      warm_s_r <= 2'h3;
      cpg_s_r  <= 2'h0;
      iopg_s_r <= 2'h0;
    end
    else
    begin
      por_s_r  <= por_s_nxt;
      warm_s_r <= warm_s_nxt;
      cpg_s_r  <= cpg_s_nxt;
      iopg_s_r <= iopg_s_nxt;
    end
  end

  wire logic por_sync  = por_s_r[1];
  wire logic warm_sync = warm_s_r[1];
  wire logic supp_ok   = cpg_s_r[1] & iopg_s_r[1];

  // ----------------------------------------------------------------------
  // Glitch filters
  // ----------------------------------------------------------------------
  logic [11:0] por_f_cnt_r, por_f_cnt_nxt;
  logic [11:0] warm_f_cnt_r, warm_f_cnt_nxt;
  logic        por_f_r, por_f_nxt;
  logic        warm_f_r, warm_f_nxt;
  logic        warm_drv;

  always_comb
  begin
    // Power-on filter: new level must persist before it is taken
    por_f_nxt     = por_f_r;
    por_f_cnt_nxt = 12'h000;
    if (por_sync != por_f_r)
    begin
      por_f_cnt_nxt = por_f_cnt_r + 12'h001;
      if (por_f_cnt_r >= FILT_CNT - 12'h001)
      begin
        por_f_nxt     = por_sync;
        por_f_cnt_nxt = 12'h000;
      end
    end
    // Warm filter: only count lows not caused by our own drive
    warm_f_nxt     = 1'b0;
    warm_f_cnt_nxt = 12'h000;
    if (!warm_sync && !warm_drv)
    begin
      warm_f_cnt_nxt = warm_f_cnt_r + 12'h001;
      if (warm_f_cnt_r >= FILT_CNT - 12'h001)
      begin
        warm_f_nxt     = 1'b1;
        warm_f_cnt_nxt = warm_f_cnt_r;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      por_f_r      <= 1'b0;
      por_f_cnt_r  <= 12'h000;
      warm_f_r     <= 1'b0;
      warm_f_cnt_r <= 12'h000;
    end
    else
    begin
      por_f_r      <= por_f_nxt;
      por_f_cnt_r  <= por_f_cnt_nxt;
      warm_f_r     <= warm_f_nxt;
      warm_f_cnt_r <= warm_f_cnt_nxt;
    end
  end

  // Power-on reset active when pin low or supply monitor reports low
  wire logic por_act = !por_f_r || !supp_ok;
  logic      warm_f_r_d;
  wire logic warm_ext = warm_f_r && !warm_f_r_d;
  wire logic int_req = |req;
  wire logic warm_evt = warm_ext || int_req;

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  purs_state_e st_r, st_nxt;
  logic [11:0] ph_cnt_r, ph_cnt_nxt;
  logic [11:0] hold_r, hold_nxt;
  logic        cpu_rst_n_r, cpu_rst_n_nxt;

  always_comb
  begin
    st_nxt        = st_r;
    ph_cnt_nxt    = ph_cnt_r + 12'h001;
    cpu_rst_n_nxt = 1'b0;
    hold_nxt      = (hold_r != 12'h000) ? hold_r - 12'h001 : 12'h000;
    unique case (st_r)
      PURS_WAIT:
      begin
        ph_cnt_nxt = 12'h000;
        if (!por_act)
        begin
          st_nxt   = PURS_OSC;
          hold_nxt = WARM_POR;
        end
      end
      PURS_OSC:
        if (ph_cnt_r == PH_OSC)
        begin
          st_nxt     = PURS_FUSE;
          ph_cnt_nxt = 12'h000;
        end
      PURS_FUSE:
        if (ph_cnt_r == PH_FUSE)
        begin
          st_nxt     = PURS_PUMP;
          ph_cnt_nxt = 12'h000;
        end
      PURS_PUMP:
        if (ph_cnt_r == PH_PUMP)
        begin
          st_nxt     = PURS_BANK;
          ph_cnt_nxt = 12'h000;
        end
      PURS_BANK:
        if (ph_cnt_r == PH_BANK)
        begin
          st_nxt        = PURS_RUN;
          ph_cnt_nxt    = 12'h000;
          cpu_rst_n_nxt = (hold_r <= 12'h001);
        end
      PURS_RUN:
      begin
        ph_cnt_nxt    = 12'h000;
        cpu_rst_n_nxt = (hold_r <= 12'h001) && !warm_evt;
        if (warm_evt && hold_r < WARM_OTH)
          hold_nxt = WARM_OTH;
      end
      default:
        st_nxt = PURS_WAIT;
    endcase
    if (por_act)
    begin
      st_nxt        = PURS_WAIT;
      ph_cnt_nxt    = 12'h000;
      hold_nxt      = WARM_POR;
      cpu_rst_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_r        <= PURS_WAIT;
      ph_cnt_r    <= 12'h000;
      hold_r      <= 12'h000;
      cpu_rst_n_r <= 1'b0;
      warm_f_r_d  <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      ph_cnt_r    <= ph_cnt_nxt;
      hold_r      <= hold_nxt;
      cpu_rst_n_r <= cpu_rst_n_nxt;
      warm_f_r_d  <= warm_f_r;
    end
  end

  // Drive low while any internal reset condition stands
  assign warm_drv = (st_r != PURS_RUN) || (hold_r != 12'h000);

  // ----------------------------------------------------------------------
  // Cause flags and outputs
  // ----------------------------------------------------------------------
  logic [15:0] exc_r, exc_nxt, glb_r, glb_nxt;
  logic [15:0] exc_set, glb_set;
  logic        por_evt_r, por_evt_nxt;
  purs_feat_s  feat_r, feat_nxt;
  logic        drv_r, drv_nxt, hiz_r, hiz_nxt;

  always_comb
  begin
    exc_set = 16'h0000;
    glb_set = 16'h0000;
    exc_set[EXC_POWERUP] = por_act && !por_evt_r;
    exc_set[EXC_WDOG]    = req.wdog;
    exc_set[EXC_STC]     = req.cpu_self_test_controller;
    exc_set[EXC_SW]      = req.sw;
    exc_set[EXC_EXT]     = warm_ext;
    glb_set[GLB_OSCFAIL] = req.osc_fail;
    glb_set[GLB_SLIP_LO] = req.pll_slip;
    glb_set[GLB_SLIP_HI] = req.pll_slip;
    // Set wins over clear; flags untouched by the reset itself
    exc_nxt     = (exc_r & ~exc_clr) | exc_set;
    glb_nxt     = (glb_r & ~glb_clr) | glb_set;
    por_evt_nxt = por_act;
    // Features clear one cycle after the processor is held, then stay off while it is held
    feat_nxt    = cpu_rst_n_r ? (feat_r | feat_en) : 3'h0;
    drv_nxt     = warm_drv || warm_evt || por_act;
    hiz_nxt     = !cpg_s_r[1];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      exc_r     <= EXC_RST;
      glb_r     <= GLB_RST;
      por_evt_r <= 1'b0;
      feat_r    <= 3'h0;
      drv_r     <= 1'b1;
      hiz_r     <= 1'b1;
    end
    else
    begin
      exc_r     <= exc_nxt;
      glb_r     <= glb_nxt;
      por_evt_r <= por_evt_nxt;
      feat_r    <= feat_nxt;
      drv_r     <= drv_nxt;
      hiz_r     <= hiz_nxt;
    end
  end

  assign exc_status           = exc_r;
  assign glb_status           = glb_r;
  assign cpu_reset_n          = cpu_rst_n_r;
  assign boot_addr            = BOOT_ADDR;
  assign warm_reset_n_line_o  = 1'b0;
  assign warm_reset_n_line_oe = drv_r;
  assign outputs_hiz          = hiz_r || !core_power_good;
  assign feat                 = feat_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  osc_phase_len_a: assert property (
    $rose(st_r == PURS_OSC) |-> (st_r == PURS_OSC)[*8])
    else $error("oscillator phase too short");
  start_gate_a: assert property (
    (st_r == PURS_WAIT) && por_act |=> st_r == PURS_WAIT)
    else $error("sequence left wait with reset active");
  bank_release_a: assert property (
    $rose(cpu_reset_n) |-> $past(st_r) inside {PURS_BANK, PURS_RUN})
    else $error("processor released outside final phase");
  drive_low_a: assert property (
    (st_r != PURS_RUN) |-> warm_reset_n_line_oe && !warm_reset_n_line_o)
    else $error("warm line not driven low during reset");
  hold_por_a: assert property (
    $fell(por_act) |=> hold_r > 12'h800)
    else $error("warm hold after power-on too short");
  hold_other_a: assert property (
    (st_r == PURS_RUN) && req.sw |=> hold_r >= 12'h01f)
    else $error("warm hold for other cause too short");
  powerup_flag_a: assert property (
    $rose(por_act) |=> exc_status[EXC_POWERUP])
    else $error("power-up flag not set");
  sw_flag_a: assert property (
    req.sw |=> exc_status[EXC_SW])
    else $error("software flag not set");
  slip_flag_a: assert property (
    req.pll_slip |=> glb_status[GLB_SLIP_HI:GLB_SLIP_LO] == 2'h3)
    else $error("slip flags not set");
  feat_off_a: assert property (
    !cpu_reset_n |=> feat == 3'h0)
    else $error("feature enabled while held");

  boot_c: cover property (st_r == PURS_BANK ##1 st_r == PURS_RUN);
  ext_c: cover property ($rose(warm_ext));
  wdog_c: cover property ((st_r == PURS_RUN) && req.wdog);

endmodule // purs_top

`default_nettype wire

// >>> hw/purs_pkg.sv
// Package of constants and types for the power-up reset sequencer
package purs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PH_CYC    = 1032;
  localparam int FUSE_PH_CYC   = 1160;
  localparam int PUMP_PH_CYC   = 688;
  localparam int BANK_PH_CYC   = 617;
  localparam int WARM_POR_CYC  = 2256;
  localparam int WARM_OTHER_CYC = 32;
  localparam int FILT_MIN_NS   = 475;
  localparam int FILT_MAX_NS   = 2000;
  // Glitches under the minimum are ignored, accept only once the maximum has passed
  localparam int FILT_MIN_CYC  = (FILT_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int FILT_CYC      = FILT_MAX_NS / CLK_PERIOD_NS;
  localparam logic [11:0] FILT_CNT = 12'(FILT_CYC);
  localparam logic [11:0] PH_OSC   = 12'(OSC_PH_CYC - 1);
  localparam logic [11:0] PH_FUSE  = 12'(FUSE_PH_CYC - 1);
  localparam logic [11:0] PH_PUMP  = 12'(PUMP_PH_CYC - 1);
  localparam logic [11:0] PH_BANK  = 12'(BANK_PH_CYC - 1);
  localparam logic [11:0] WARM_POR = 12'(WARM_POR_CYC);
  localparam logic [11:0] WARM_OTH = 12'(WARM_OTHER_CYC);
  localparam logic [31:0] BOOT_ADDR = 32'h00000000;

  // ----------------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------------
  localparam int EXC_POWERUP = 15;
  localparam int EXC_WDOG    = 13;
  localparam int EXC_STC     = 5;
  localparam int EXC_SW      = 4;
  localparam int EXC_EXT     = 3;
  localparam int GLB_OSCFAIL = 0;
  localparam int GLB_SLIP_LO = 8;
  localparam int GLB_SLIP_HI = 9;
  localparam logic [15:0] EXC_RST = 16'h0000;
  localparam logic [15:0] GLB_RST = 16'h0000;

  typedef enum logic [2:0]
  {
    PURS_WAIT = 3'h0,
    PURS_OSC  = 3'h1,
    PURS_FUSE = 3'h2,
    PURS_PUMP = 3'h3,
    PURS_BANK = 3'h4,
    PURS_RUN  = 3'h5
  } purs_state_e;

  // Internal reset requests
  typedef struct packed
  {
    logic osc_fail;
    logic pll_slip;
    logic wdog;
    logic cpu_self_test_controller;
    logic sw;
  } purs_req_s;

  // Software enables of processor features
  typedef struct packed
  {
    logic tcm_ecc;
    logic vic_port;
    logic mpu;
  } purs_feat_s;

endpackage

// >>> verification/purs_partner.sv
// Supply supervisor and warm reset line model
`timescale 1ns/10ps
`default_nettype none
module purs_partner
(
  input  wire logic core_ok,
  input  wire logic io_ok,
  input  wire logic por_hold,
  input  wire logic ext_pull,
  input  wire logic dut_oe,
  output var  logic por_n,
  output var  logic core_good,
  output var  logic io_good,
  output var  logic warm_line
);
  // ----
  // Supervisor and pulled-up warm line
  // ----
  always_comb
  begin
    core_good = core_ok;
    io_good   = io_ok;
    por_n     = core_ok & io_ok & ~por_hold;
    warm_line = ~(dut_oe | ext_pull);
  end
endmodule // purs_partner
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the power-up reset sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import purs_pkg::*;
  typedef struct packed
  {
    logic [4:0]  r;
    logic [15:0] e;
    logic [15:0] g;
  } purs_row_s;
  logic        clk;
  logic        rstn;
  logic        core_ok, io_ok, por_hold, ext_pull;
  logic        por_n, cg, ig, wl, wo, oe, cpu_n, hiz;
  logic [15:0] exc, glb, exc_clr, glb_clr;
  logic [31:0] baddr;
  purs_req_s   req;
  purs_feat_s  feat_en, feat;
  int          n, n_mismatch, cmp_count;
  purs_row_s   rows [5] = '{
    '{5'b00100, 16'h2000, 16'h0000},
    '{5'b00010, 16'h0020, 16'h0000},
    '{5'b00001, 16'h0010, 16'h0000},
    '{5'b10000, 16'h0000, 16'h0001},
    '{5'b01000, 16'h0000, 16'h0300}};

  purs_partner sup_u (.core_ok, .io_ok, .por_hold, .ext_pull,
    .dut_oe(oe), .por_n, .core_good(cg), .io_good(ig), .warm_line(wl));
  purs_top dut_u (.clk, .rstn, .power_on_reset_n_pin(por_n),
    .core_power_good(cg), .io_power_good(ig), .warm_reset_n_line_i(wl),
    .warm_reset_n_line_o(wo), .warm_reset_n_line_oe(oe), .req,
    .feat_en, .exc_clr, .glb_clr, .exc_status(exc), .glb_status(glb),
    .cpu_reset_n(cpu_n), .boot_addr(baddr), .outputs_hiz(hiz), .feat);

  // ----
  // Clock, tasks, watchdog
  // ----
  always #50 clk = ~clk;

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask

  task automatic wait_cpu(output int k);
    k = 0;
    while (cpu_n !== 1'b1 && k < 5000)
    begin
      tick(1);
      k++;
    end
    if (k >= 5000) n_mismatch++;
  endtask

  task automatic clear_flags;
    exc_clr = 16'hffff;
    glb_clr = 16'hffff;
    tick(1);
    exc_clr = 16'h0000;
    glb_clr = 16'h0000;
    tick(1);
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    core_ok = 1'b1;
    io_ok = 1'b0;
    por_hold = 1'b0;
    ext_pull = 1'b0;
    req = '0;
    feat_en = '0;
    exc_clr = 16'h0000;
    glb_clr = 16'h0000;
    n_mismatch = 0;
    cmp_count = 0;
    tick(20);
    rstn = 1'b1;
    tick(4000);
    check("cpu_io_bad", 32'(cpu_n), 0);
    io_ok = 1'b1;
    tick(2256);
    check("oe_por", 32'(oe), 1);
    wait_cpu(n);
    check("boot", 32'(n + 2256 >= 3497 && n + 2256 <= 3560), 1);
    check("boot_addr", baddr, 0);
    check("feat_rst", 32'(feat), 0);
    check("hiz_ok", 32'(hiz), 0);
    clear_flags();
    feat_en = 3'b101;
    tick(1);
    feat_en = '0;
    tick(2);
    check("feat_set", 32'(feat), 5);
    foreach (rows[i])
    begin
      req = rows[i].r;
      tick(1);
      req = '0;
      n = 0;
      while (oe !== 1'b1 && n < 50)
      begin
        tick(1);
        n++;
      end
      check("warm_o", 32'({oe, wo}), 2);
      n = 0;
      while (oe === 1'b1 && n < 5000)
      begin
        tick(1);
        n++;
      end
      check("hold", 32'(n >= 32), 1);
      wait_cpu(n);
      tick(2);
      check("exc", 32'(exc), 32'(rows[i].e));
      check("glb", 32'(glb), 32'(rows[i].g));
      clear_flags();
    end
    check("feat_after", 32'(feat), 0);
    ext_pull = 1'b1;
    tick(4);
    ext_pull = 1'b0;
    tick(40);
    check("warm_glitch", 32'({cpu_n, exc}), 32'h10000);
    ext_pull = 1'b1;
    tick(25);
    ext_pull = 1'b0;
    tick(5);
    wait_cpu(n);
    check("ext_rst", 32'(exc), 32'h0008);
    clear_flags();
    por_hold = 1'b1;
    tick(4);
    por_hold = 1'b0;
    tick(40);
    check("por_glitch", 32'({cpu_n, exc}), 32'h10000);
    por_hold = 1'b1;
    tick(30);
    check("por_cpu", 32'(cpu_n), 0);
    por_hold = 1'b0;
    tick(2256);
    check("oe_por2", 32'(oe), 1);
    wait_cpu(n);
    check("boot2", 32'(n + 2256 >= 3497 && n + 2256 <= 3560), 1);
    check("powerup", 32'(exc), 32'h8000);
    req = 5'b00100;
    tick(1);
    req = '0;
    tick(5);
    wait_cpu(n);
    tick(2);
    check("sticky", 32'(exc), 32'ha000);
    core_ok = 1'b0;
    tick(3);
    check("hiz_bad", 32'({hiz, cpu_n}), 2);
    core_ok = 1'b1;
    wait_cpu(n);
    tick(2);
    check("hiz_back", 32'(hiz), 0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
